// [dbx_regs.sv]
// Debug exception state registers: trace breakpoint control, complex break status,
// and debug resume program counter.
// Assumes the core pipeline drives coprocessor access and exception strobes
// synchronously to ref_clk_i, one cycle each.

// Contract
// RULE1: Trace breakpoint control exists only with hardware breakpoints and trace present.
// RULE2: Bit 15 enables instruction breakpoint triggers to tracing; read/write, resets zero.
// RULE3: Enable one passes instruction breakpoint triggers to trace; zero blocks them.
// RULE4: Six-bit read/write trace mask in bits 5:0, bit 0 first breakpoint.
// RULE5: Mask bits of unimplemented instruction breakpoints are ignored by trace logic.
// RULE6: Mask bit one: matching breakpoint trigger starts tracing.
// RULE7: Mask bit zero: matching breakpoint trigger stops tracing.
// RULE8: Complex break status exists only with complex hardware breakpoints.
// RULE9: Status bits 31:4 read zero; flags undefined until first debug exception.
// RULE10: Status bit 3 records a primed complex breakpoint on last exception.
// RULE11: Status bit 2 records a data qualified complex breakpoint on last exception.
// RULE12: Status bit 1 records a tuple breakpoint seen on last exception.
// RULE13: Status bit 0 records an active pass counter on last exception.
// RULE14: Resume program counter is read/write, holds address to resume after debug.
// RULE15: Precise debug exception loads the causing instruction's virtual address.
// RULE16: In a delay slot, capture the preceding branch address and set delay flag.
// RULE17: Asynchronous debug exception captures the address where execution should resume.
// RULE18: With compressed set, read returns upper 31 bits plus mode bit 0.
// RULE19: Write stores source bits 31:1, forcing counter bit 0 to zero.
// RULE20: Write clears upper mode bit and loads lower mode bit from source bit 0.
// RULE21: Debug return jumps to resume counter; its reset value is undefined.
module dbx_regs #(
   parameter bit HAS_HW_BP = 1'b1,
   parameter bit HAS_TRACE = 1'b1,
   parameter bit HAS_CPLX_BP = 1'b1,
   parameter bit HAS_COMPRESSED = 1'b1,
   parameter int NUM_IBP = 2
) (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic coproc_write_op_i,
   input wire logic coproc_read_op_i,
   input wire logic [4:0] cp_reg_i,
   input wire logic [2:0] cp_sel_i,
   input wire logic [31:0] cp_wdata_i,
   output logic [31:0] cp_rdata_o,
   output logic cp_rvalid_o,
   input wire logic [dbx_pkg::DBX_MASK_W-1:0] instr_bp_trig_i,
   output logic trace_start_o,
   output logic trace_stop_o,
   input wire logic dbg_exc_i,
   input wire logic dbg_exc_async_i,
   input wire logic dbg_in_delay_slot_i,
   input wire logic [31:0] dbg_exc_pc_i,
   input wire logic [31:0] dbg_branch_pc_i,
   input wire logic [31:0] dbg_resume_pc_i,
   input wire logic [1:0] dbg_exc_isa_i,
   input wire logic prime_seen_i,
   input wire logic data_qual_seen_i,
   input wire logic tuple_seen_i,
   input wire logic pass_count_seen_i,
   input wire logic debug_return_op_i,
   output logic debug_delay_slot_flag_o,
   output logic redirect_o,
   output logic [31:0] redirect_pc_o,
   output logic [1:0] instr_set_mode_bits_o
);

   // ****************************************************************
   // Address decoding.
   // ****************************************************************
   localparam bit TBC_ON = HAS_HW_BP && HAS_TRACE;

   function automatic dbx_pkg::dbx_slot_t decode(input logic [4:0] r, input logic [2:0] s);
      if (TBC_ON && r == dbx_pkg::DBX_REG_TBC && s == dbx_pkg::DBX_SEL_TBC) begin // see RULE1
         return dbx_pkg::DBX_SLOT_TBC;
      end else if (HAS_CPLX_BP && r == dbx_pkg::DBX_REG_CBS && s == dbx_pkg::DBX_SEL_CBS) begin // see RULE8
         return dbx_pkg::DBX_SLOT_CBS;
      end else if (r == dbx_pkg::DBX_REG_DRP && s == dbx_pkg::DBX_SEL_DRP) begin
         return dbx_pkg::DBX_SLOT_DRP;
      end else begin
         return dbx_pkg::DBX_SLOT_NONE;
      end
   endfunction

   dbx_pkg::dbx_slot_t slot_w;
   logic wr_tbc_w;
   logic wr_drp_w;

   assign slot_w = decode(cp_reg_i, cp_sel_i);
   assign wr_tbc_w = coproc_write_op_i && (slot_w == dbx_pkg::DBX_SLOT_TBC);
   assign wr_drp_w = coproc_write_op_i && (slot_w == dbx_pkg::DBX_SLOT_DRP);

   // ****************************************************************
   // Trace breakpoint control.
   // ****************************************************************
   logic tbc_ie_r;
   logic [dbx_pkg::DBX_MASK_W-1:0] tbc_mask_r;

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tbc_ie_r <= dbx_pkg::DBX_IE_RST; // see RULE2
         tbc_mask_r <= dbx_pkg::DBX_MASK_RST;
      end else if (wr_tbc_w) begin
         tbc_ie_r <= cp_wdata_i[dbx_pkg::DBX_TBC_IE_POS]; // see RULE2
         tbc_mask_r <= cp_wdata_i[dbx_pkg::DBX_MASK_W-1:0]; // see RULE4
      end
   end

   generate
      if (TBC_ON) begin : g_route
         dbx_trig_route #(
            .NUM_IBP(NUM_IBP)
         ) u_route (
            .ref_clk_i(ref_clk_i),
            .sys_rst_i(sys_rst_i),
            .enable_i(tbc_ie_r),
            .mask_i(tbc_mask_r),
            .trig_i(instr_bp_trig_i),
            .trace_start_o(trace_start_o),
            .trace_stop_o(trace_stop_o)
         ); // see RULE3
      end else begin : g_noroute
         always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               trace_start_o <= 1'b0;
               trace_stop_o <= 1'b0;
            end else begin
               trace_start_o <= 1'b0;
               trace_stop_o <= 1'b0;
            end
         end
      end
   endgenerate

   // ****************************************************************
   // Complex break status, captured on each debug exception.
   // ****************************************************************
   logic [dbx_pkg::DBX_CBS_W-1:0] cbs_r;

   always_ff @(posedge ref_clk_i) begin
      if (dbg_exc_i) begin
         cbs_r[3] <= prime_seen_i; // see RULE10
         cbs_r[2] <= data_qual_seen_i; // see RULE11
         cbs_r[1] <= tuple_seen_i; // see RULE12
         cbs_r[0] <= pass_count_seen_i; // see RULE13
      end
   end

   // ****************************************************************
   // Debug resume program counter and mode bits.
   // ****************************************************************
   logic [31:0] drp_r;
   logic [1:0] isa_r;
   logic dbd_r;

   always_ff @(posedge ref_clk_i) begin
      if (dbg_exc_i) begin
         if (dbg_exc_async_i) begin
            drp_r <= dbg_resume_pc_i; // see RULE17
         end else if (dbg_in_delay_slot_i) begin
            drp_r <= dbg_branch_pc_i; // see RULE16
         end else begin
            drp_r <= dbg_exc_pc_i; // see RULE15
         end
      end else if (wr_drp_w) begin
         drp_r <= {cp_wdata_i[31:1], 1'b0}; // see RULE19
      end
   end

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         isa_r <= dbx_pkg::DBX_ISA_RST;
         dbd_r <= 1'b0;
      end else if (dbg_exc_i) begin
         isa_r <= dbg_exc_isa_i;
         dbd_r <= dbg_in_delay_slot_i && !dbg_exc_async_i; // see RULE16
      end else if (wr_drp_w) begin
         isa_r <= {1'b0, HAS_COMPRESSED ? cp_wdata_i[0] : 1'b0}; // see RULE20
      end
   end

   // ****************************************************************
   // Read port.
   // ****************************************************************
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cp_rdata_o <= 32'h0000_0000;
         cp_rvalid_o <= 1'b0;
      end else begin
         cp_rvalid_o <= coproc_read_op_i;
         if (!coproc_read_op_i) begin
            cp_rdata_o <= 32'h0000_0000;
         end else if (slot_w == dbx_pkg::DBX_SLOT_TBC) begin
            cp_rdata_o <= {16'h0000, tbc_ie_r, 9'h000, tbc_mask_r};
         end else if (slot_w == dbx_pkg::DBX_SLOT_CBS) begin
            cp_rdata_o <= {28'h000_0000, cbs_r}; // see RULE9
         end else if (slot_w == dbx_pkg::DBX_SLOT_DRP) begin
            cp_rdata_o <= HAS_COMPRESSED ? {drp_r[31:1], isa_r[0]} : drp_r; // see RULE18
         end else begin
            cp_rdata_o <= 32'h0000_0000;
         end
      end
   end

   // ****************************************************************
   // Debug return redirect and status outputs.
   // ****************************************************************
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         redirect_o <= 1'b0;
         redirect_pc_o <= 32'h0000_0000;
         debug_delay_slot_flag_o <= 1'b0;
         instr_set_mode_bits_o <= dbx_pkg::DBX_ISA_RST;
      end else begin
         redirect_o <= debug_return_op_i; // see RULE21
         redirect_pc_o <= drp_r; // see RULE14
         debug_delay_slot_flag_o <= dbd_r;
         instr_set_mode_bits_o <= isa_r;
      end
   end

endmodule // dbx_regs

// [dbx_pkg.sv]
// Package of constants for the debug exception state registers.
// Assumes a coprocessor register port addressed by register number and select.
package dbx_pkg;

   // ****************************************************************
   // Coprocessor register addresses.
   // ****************************************************************
   localparam logic [4:0] DBX_REG_TBC = 5'h17;
   localparam logic [2:0] DBX_SEL_TBC = 3'h4;
   localparam logic [4:0] DBX_REG_CBS = 5'h17;
   localparam logic [2:0] DBX_SEL_CBS = 3'h6;
   localparam logic [4:0] DBX_REG_DRP = 5'h18;
   localparam logic [2:0] DBX_SEL_DRP = 3'h0;

   // ****************************************************************
   // Field layout and reset values.
   // ****************************************************************
   localparam int DBX_TBC_IE_POS = 15;
   localparam int DBX_MASK_W = 6;
   localparam int DBX_CBS_W = 4;
   localparam logic [DBX_MASK_W-1:0] DBX_MASK_RST = 6'h00;
   localparam logic DBX_IE_RST = 1'h0;
   localparam logic [1:0] DBX_ISA_RST = 2'h0;

   // ****************************************************************
   // Register slots selected by a coprocessor access.
   // ****************************************************************
   typedef enum logic [3:0] {
      DBX_SLOT_NONE = 4'h1,
      DBX_SLOT_TBC = 4'h2,
      DBX_SLOT_CBS = 4'h4,
      DBX_SLOT_DRP = 4'h8
   } dbx_slot_t;

endpackage

// [dbx_trig_route.sv]
// Routing of instruction breakpoint triggers to trace start and stop pulses.
// Assumes trigger pulses are synchronous to the core clock.
module dbx_trig_route #(
   parameter int NUM_IBP = 2
) (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic enable_i,
   input wire logic [dbx_pkg::DBX_MASK_W-1:0] mask_i,
   input wire logic [dbx_pkg::DBX_MASK_W-1:0] trig_i,
   output logic trace_start_o,
   output logic trace_stop_o
);

   logic [dbx_pkg::DBX_MASK_W-1:0] impl_w;
   logic [dbx_pkg::DBX_MASK_W-1:0] live_w;

   genvar g;
   generate
      for (g = 0; g < dbx_pkg::DBX_MASK_W; g++) begin : g_impl
         assign impl_w[g] = (g < NUM_IBP); // see RULE5
      end
   endgenerate

   assign live_w = enable_i ? (trig_i & impl_w) : '0; // see RULE3

   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         trace_start_o <= 1'b0;
         trace_stop_o <= 1'b0;
      end else begin
         trace_start_o <= |(live_w & mask_i); // see RULE6
         trace_stop_o <= |(live_w & ~mask_i); // see RULE7
      end
   end

endmodule // dbx_trig_route

// [dbx_regs_assertions.sv]
// Checker of the debug exception state registers at the ports of dbx_regs.
// Assumes dbx_pkg is compiled first and the reset is active high.
module dbx_regs_chk (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic coproc_write_op_i,
   input wire logic coproc_read_op_i,
   input wire logic [4:0] cp_reg_i,
   input wire logic [2:0] cp_sel_i,
   input wire logic [31:0] cp_wdata_i,
   input wire logic [31:0] cp_rdata_o,
   input wire logic cp_rvalid_o,
   input wire logic [dbx_pkg::DBX_MASK_W-1:0] instr_bp_trig_i,
   input wire logic trace_start_o,
   input wire logic trace_stop_o,
   input wire logic dbg_exc_i,
   input wire logic dbg_exc_async_i,
   input wire logic dbg_in_delay_slot_i,
   input wire logic [31:0] dbg_exc_pc_i,
   input wire logic [31:0] dbg_branch_pc_i,
   input wire logic [31:0] dbg_resume_pc_i,
   input wire logic [1:0] dbg_exc_isa_i,
   input wire logic debug_return_op_i,
   input wire logic debug_delay_slot_flag_o,
   input wire logic redirect_o,
   input wire logic [31:0] redirect_pc_o,
   input wire logic [1:0] instr_set_mode_bits_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (sys_rst_i);
   AST_RD_VALID: assert property (cp_rvalid_o == $past(coproc_read_op_i))
      else $error("read valid misplaced");
   AST_RD_IDLE: assert property (!cp_rvalid_o |-> cp_rdata_o == 32'h0)
      else $error("read data not zero");
   AST_CBS_HIGH: assert property (
      coproc_read_op_i && cp_reg_i == dbx_pkg::DBX_REG_CBS && cp_sel_i == dbx_pkg::DBX_SEL_CBS
      |=> cp_rdata_o[31:4] == 28'h0) else $error("status high bits set");
   AST_TRIG_IDLE: assert property (
      instr_bp_trig_i[1:0] == 2'h0 |=> !trace_start_o && !trace_stop_o)
      else $error("trace pulse without trigger");
   AST_RETURN: assert property (redirect_o == $past(debug_return_op_i))
      else $error("redirect misplaced");
   AST_DELAY: assert property (
      dbg_exc_i && !dbg_exc_async_i && dbg_in_delay_slot_i ##1 !dbg_exc_i && !coproc_write_op_i
      |=> debug_delay_slot_flag_o && redirect_pc_o == $past(dbg_branch_pc_i, 2))
      else $error("delay slot capture wrong");
   AST_PRECISE: assert property (
      dbg_exc_i && !dbg_exc_async_i && !dbg_in_delay_slot_i ##1 !dbg_exc_i && !coproc_write_op_i
      |=> redirect_pc_o == $past(dbg_exc_pc_i, 2) && instr_set_mode_bits_o == $past(dbg_exc_isa_i, 2))
      else $error("precise capture wrong");
   AST_ASYNC: assert property (
      dbg_exc_i && dbg_exc_async_i ##1 !dbg_exc_i && !coproc_write_op_i
      |=> !debug_delay_slot_flag_o && redirect_pc_o == $past(dbg_resume_pc_i, 2))
      else $error("async capture wrong");
   AST_WR_PC: assert property (
      coproc_write_op_i && !dbg_exc_i && cp_reg_i == dbx_pkg::DBX_REG_DRP
      && cp_sel_i == dbx_pkg::DBX_SEL_DRP ##1 !dbg_exc_i
      && !coproc_write_op_i |=> redirect_pc_o == ($past(cp_wdata_i, 2) & 32'hFFFFFFFE)
      && instr_set_mode_bits_o == 2'($past(cp_wdata_i, 2) & 32'h1)) else $error("pc write wrong");
endmodule // dbx_regs_chk

bind dbx_regs dbx_regs_chk u_chk (.*);

// [debug_exception_state_regs_tb.sv]
// Testbench of the debug exception state registers.
// Assumes dbx_pkg, dbx_regs and its checker are compiled first.
module debug_exception_state_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, coproc_write_op_i = 1'b0, coproc_read_op_i = 1'b0;
   logic dbg_exc_i = 1'b0, dbg_exc_async_i = 1'b0, dbg_in_delay_slot_i = 1'b0;
   logic prime_seen_i = 1'b0, data_qual_seen_i = 1'b0, tuple_seen_i = 1'b0;
   logic pass_count_seen_i = 1'b0, debug_return_op_i = 1'b0;
   logic cp_rvalid_o, trace_start_o, trace_stop_o, redirect_o, debug_delay_slot_flag_o;
   logic [4:0] cp_reg_i = 5'h00;
   logic [2:0] cp_sel_i = 3'h0;
   logic [1:0] dbg_exc_isa_i = 2'h0, instr_set_mode_bits_o;
   logic [5:0] instr_bp_trig_i = 6'h00;
   logic [31:0] cp_wdata_i = 32'h0, dbg_exc_pc_i = 32'h0, dbg_branch_pc_i = 32'h0;
   logic [31:0] dbg_resume_pc_i = 32'h0, cp_rdata_o, redirect_pc_o, d, e, xpc;
   logic [31:0] seed = 32'h000143E2;
   int failures = 0, comparisons = 0, cyc = 0;
   dbx_regs u_dut (.*);
   always #50 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         failures++;
         $display("mismatch at %0t: timeout", $time);
         test_done();
      end
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [1:0] route(logic [31:0] c, int i);
      return (c[15] && i < 2) ? {c[i], !c[i]} : 2'h0;
   endfunction
   task automatic test_done();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] r, input logic [2:0] s, input logic [31:0] v);
      @(posedge ref_clk_i);
      {coproc_write_op_i, cp_reg_i, cp_sel_i, cp_wdata_i} <= {1'b1, r, s, v};
      @(posedge ref_clk_i);
      coproc_write_op_i <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] r, input logic [2:0] s, output logic [31:0] v);
      @(posedge ref_clk_i);
      {coproc_read_op_i, cp_reg_i, cp_sel_i} <= {1'b1, r, s};
      @(posedge ref_clk_i);
      coproc_read_op_i <= 1'b0;
      @(negedge ref_clk_i);
      chk({31'h0, cp_rvalid_o}, 32'h1, "read valid");
      v = cp_rdata_o;
   endtask
   task automatic pulse(input int i);
      @(posedge ref_clk_i);
      if (i < 6) instr_bp_trig_i <= 6'h01 << i;
      else debug_return_op_i <= 1'b1;
      @(posedge ref_clk_i);
      {instr_bp_trig_i, debug_return_op_i} <= 7'h00;
      @(negedge ref_clk_i);
   endtask
   initial begin
      repeat (6) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      rd(dbx_pkg::DBX_REG_TBC, dbx_pkg::DBX_SEL_TBC, d);
      chk(d, 32'h0, "control reset");
      for (int k = 0; k < 36; k++) begin
         e = (k == 0) ? 32'hFFFFFFFF : rnd();
         wr(dbx_pkg::DBX_REG_TBC, dbx_pkg::DBX_SEL_TBC, e);
         rd(dbx_pkg::DBX_REG_TBC, dbx_pkg::DBX_SEL_TBC, d);
         chk(d, {16'h0, e[15], 9'h0, e[5:0]}, "control");
         pulse(k % 6);
         chk({30'h0, trace_start_o, trace_stop_o}, {30'h0, route(e, k % 6)}, "trace");
      end
      $display("test control done");
      for (int k = 0; k < 12; k++) begin
         e = rnd();
         wr(dbx_pkg::DBX_REG_DRP, dbx_pkg::DBX_SEL_DRP, e);
         rd(dbx_pkg::DBX_REG_DRP, dbx_pkg::DBX_SEL_DRP, d);
         chk(d, e, "resume read");
         chk(redirect_pc_o, e & 32'hFFFFFFFE, "resume pc");
         chk({30'h0, instr_set_mode_bits_o}, {31'h0, e[0]}, "mode");
      end
      $display("test resume write done");
      for (int k = 0; k < 12; k++) begin
         @(posedge ref_clk_i);
         {dbg_exc_i, dbg_exc_async_i, dbg_in_delay_slot_i} <= {1'b1, k % 3 == 2, k % 3 == 1};
         {dbg_exc_pc_i, dbg_branch_pc_i, dbg_resume_pc_i} <= {rnd(), rnd(), rnd()};
         {prime_seen_i, data_qual_seen_i, tuple_seen_i, pass_count_seen_i, dbg_exc_isa_i} <= 6'(rnd());
         @(posedge ref_clk_i);
         dbg_exc_i <= 1'b0;
         xpc = dbg_exc_async_i ? dbg_resume_pc_i : dbg_in_delay_slot_i ? dbg_branch_pc_i : dbg_exc_pc_i;
         e = {28'h0, prime_seen_i, data_qual_seen_i, tuple_seen_i, pass_count_seen_i};
         pulse(6);
         chk({31'h0, redirect_o}, 32'h1, "return");
         chk(redirect_pc_o, xpc, "captured pc");
         chk({31'h0, debug_delay_slot_flag_o}, {31'h0, k % 3 == 1}, "delay flag");
         wr(dbx_pkg::DBX_REG_CBS, dbx_pkg::DBX_SEL_CBS, rnd());
         rd(dbx_pkg::DBX_REG_CBS, dbx_pkg::DBX_SEL_CBS, d);
         chk(d, e, "status");
         rd(dbx_pkg::DBX_REG_DRP, dbx_pkg::DBX_SEL_DRP, d);
         chk(d, {xpc[31:1], dbg_exc_isa_i[0]}, "resume read");
         rd(5'h1F, 3'h7, d);
         chk(d, 32'h0, "unmapped");
      end
      $display("test exceptions done");
      test_done();
   end
endmodule // debug_exception_state_regs_tb
